// File: hw/mgcs_defines.vh
// Register offsets, field positions, encodings and reset values of the magnetometer control block
`ifndef MGCS_DEFINES_VH
`define MGCS_DEFINES_VH
`define MGCS_ADDR_STATUS_ONE   8'h02
`define MGCS_ADDR_X_LOW        8'h03
`define MGCS_ADDR_Z_HIGH       8'h08
`define MGCS_ADDR_STATUS_TWO   8'h09
`define MGCS_ADDR_CONTROL_ONE  8'h0a
`define MGCS_ADDR_CONTROL_TWO  8'h0b
`define MGCS_ADDR_SELF_TEST    8'h0c
`define MGCS_ADDR_FACTORY_ONE  8'h0d
`define MGCS_ADDR_FACTORY_TWO  8'h0e
`define MGCS_ADDR_DISABLE_KEY  8'h0f
`define MGCS_ADDR_SENS_X       8'h10
`define MGCS_ADDR_SENS_Y       8'h11
`define MGCS_ADDR_SENS_Z       8'h12
`define MGCS_BIT_OVERFLOW      3
`define MGCS_BIT_WIDTH         4
`define MGCS_BIT_SOFT_RESET    0
`define MGCS_BIT_SELF_FIELD    6
`define MGCS_MODE_POWER_DOWN   4'h0
`define MGCS_MODE_SINGLE       4'h1
`define MGCS_MODE_CONT_ONE     4'h2
`define MGCS_MODE_CONT_TWO     4'h6
`define MGCS_MODE_EXT_TRIG     4'h4
`define MGCS_MODE_SELF_TEST    4'h8
`define MGCS_MODE_FUSE         4'hf
`define MGCS_DISABLE_CODE      8'h1b
`define MGCS_START_COUNT       4'h8
`define MGCS_RESET_BYTE        8'h00
`endif

// File: hw/mgcs_control_status.v
// Register file, mode decode and serial-interface lock of the magnetometer control block
`timescale 1ns/1ps
`include "mgcs_defines.vh"

// What this block does
// - Overflow sets status bit three while measuring
// - Overflow flag clears when next measurement starts
// - Status bit four mirrors output width setting
// - Data read in continuous or external-trigger mode opens interval until status two read
// - Decode four-bit mode field to six modes
// - Control bit four selects 14/16-bit output
// - Written mode code becomes the operating mode
// - Control one write clears registers 02h-09h
// - Soft reset bit clears all, self-clears
// - Self-test field bit drives internal field
// - Serial interface enabled, key code disables it
// - While disabled, other key writes are ignored
// - Reset or eight starts re-enable interface
// - Fuse sensitivity bytes readable at 10h-12h
// - Sensitivity bytes valid only in fuse mode
// - Results two's complement, low byte first
module mgcs_control_status #(
  parameter [7:0] SENS_X = 8'h80,  // Arbitrary fuse contents
  parameter [7:0] SENS_Y = 8'h80,
  parameter [7:0] SENS_Z = 8'h80
) (
  input  wire        clk,
  input  wire        reset,
  input  wire        reg_write,
  input  wire        reg_read,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  output reg         reg_rvalid,
  input  wire        start_condition,
  input  wire        other_byte,
  input  wire        meas_start,
  input  wire        meas_done,
  input  wire        meas_overflow,
  input  wire        meas_overrun,
  input  wire [15:0] meas_x,
  input  wire [15:0] meas_y,
  input  wire [15:0] meas_z,
  output reg  [3:0]  op_mode,
  output reg         output_16bit,
  output reg         self_field_on,
  output reg         serial_enabled,
  output reg         data_read_active,
  output reg         mode_power_down,
  output reg         mode_single,
  output reg         mode_continuous,
  output reg         mode_ext_trigger,
  output reg         mode_self_test,
  output reg         mode_fuse
);

  reg  [7:0]  self_test_control;
  reg  [7:0]  factory_test_one;
  reg  [7:0]  factory_test_two;
  reg  [7:0]  serial_disable_key;
  reg         sensor_overflow_flag;
  reg         data_ready;
  reg         data_overrun;
  reg  [47:0] result;
  reg  [3:0]  start_run;
  reg  [7:0]  next_rdata;
  reg  [3:0]  next_op_mode;
  reg         next_output_16bit;
  reg  [7:0]  next_self_test_control;
  reg  [7:0]  next_factory_test_one;
  reg  [7:0]  next_factory_test_two;
  reg  [5:0]  next_mode;
  reg         next_overflow;
  reg         next_data_ready;
  reg         next_data_overrun;
  reg  [47:0] next_result;
  reg         next_read_active;
  reg         next_serial_enabled;
  reg  [7:0]  next_disable_key;
  reg  [3:0]  next_start_run;

  // One-hot mode codes, bit order fuse down to power-down
  localparam [5:0] MODE_OH_POWER_DOWN = 6'h01;
  localparam [5:0] MODE_OH_SINGLE     = 6'h02;
  localparam [5:0] MODE_OH_CONTINUOUS = 6'h04;
  localparam [5:0] MODE_OH_EXT_TRIG   = 6'h08;
  localparam [5:0] MODE_OH_SELF_TEST  = 6'h10;
  localparam [5:0] MODE_OH_FUSE       = 6'h20;

  // Writes and reads only reach the registers while the interface is live
  wire wr       = reg_write & serial_enabled;
  wire rd       = reg_read & serial_enabled;
  wire soft_rst = wr & (reg_addr == `MGCS_ADDR_CONTROL_TWO) & reg_wdata[`MGCS_BIT_SOFT_RESET];
  wire ctl1_wr  = wr & (reg_addr == `MGCS_ADDR_CONTROL_ONE);
  wire data_rd  = rd & (reg_addr >= `MGCS_ADDR_X_LOW) & (reg_addr <= `MGCS_ADDR_Z_HIGH);
  wire st2_rd   = rd & (reg_addr == `MGCS_ADDR_STATUS_TWO);
  wire st_rd    = data_rd | st2_rd;
  wire measuring = mode_single | mode_continuous | mode_ext_trigger | mode_self_test;
  wire streaming = mode_continuous | mode_ext_trigger;

  function [5:0] mgcs_decode;
    input [3:0] code;
    begin
      case (code)
        `MGCS_MODE_POWER_DOWN: mgcs_decode = MODE_OH_POWER_DOWN;
        `MGCS_MODE_SINGLE:     mgcs_decode = MODE_OH_SINGLE;
        `MGCS_MODE_CONT_ONE:   mgcs_decode = MODE_OH_CONTINUOUS;
        `MGCS_MODE_CONT_TWO:   mgcs_decode = MODE_OH_CONTINUOUS;
        `MGCS_MODE_EXT_TRIG:   mgcs_decode = MODE_OH_EXT_TRIG;
        `MGCS_MODE_SELF_TEST:  mgcs_decode = MODE_OH_SELF_TEST;
        `MGCS_MODE_FUSE:       mgcs_decode = MODE_OH_FUSE;
        // Prohibited codes fall back to power-down rather than a half-decoded mode
        default:               mgcs_decode = MODE_OH_POWER_DOWN;
      endcase
    end
  endfunction

  wire [5:0] dec = mgcs_decode(reg_wdata[3:0]);

  // Control and mode state
  always @* begin
    next_op_mode           = op_mode;
    next_output_16bit      = output_16bit;
    next_self_test_control = self_test_control;
    next_factory_test_one  = factory_test_one;
    next_factory_test_two  = factory_test_two;
    next_mode              = {mode_fuse, mode_self_test, mode_ext_trigger,
                              mode_continuous, mode_single, mode_power_down};
    if (wr) begin
      case (reg_addr)
        `MGCS_ADDR_CONTROL_ONE: begin
          next_op_mode      = reg_wdata[3:0];
          next_output_16bit = reg_wdata[`MGCS_BIT_WIDTH];
          next_mode         = dec;
        end
        `MGCS_ADDR_SELF_TEST:   next_self_test_control = reg_wdata;
        `MGCS_ADDR_FACTORY_ONE: next_factory_test_one  = reg_wdata;
        `MGCS_ADDR_FACTORY_TWO: next_factory_test_two  = reg_wdata;
        default: ;
      endcase
    end
  end

  always @(posedge clk) begin
    if (reset | soft_rst) begin
      op_mode           <= 4'h0;
      output_16bit      <= 1'b0;
      self_test_control <= `MGCS_RESET_BYTE;
      factory_test_one  <= `MGCS_RESET_BYTE;
      factory_test_two  <= `MGCS_RESET_BYTE;
      mode_power_down   <= 1'b1;
      mode_single       <= 1'b0;
      mode_continuous   <= 1'b0;
      mode_ext_trigger  <= 1'b0;
      mode_self_test    <= 1'b0;
      mode_fuse         <= 1'b0;
    end else begin
      op_mode           <= next_op_mode;
      output_16bit      <= next_output_16bit;
      self_test_control <= next_self_test_control;
      factory_test_one  <= next_factory_test_one;
      factory_test_two  <= next_factory_test_two;
      mode_power_down   <= next_mode[0];
      mode_single       <= next_mode[1];
      mode_continuous   <= next_mode[2];
      mode_ext_trigger  <= next_mode[3];
      mode_self_test    <= next_mode[4];
      mode_fuse         <= next_mode[5];
    end
  end

  always @(posedge clk) begin
    if (reset | soft_rst)
      self_field_on <= 1'b0;
    else
      self_field_on <= self_test_control[`MGCS_BIT_SELF_FIELD];
  end

  // Status and measurement data, wiped by any control one write
  always @* begin
    next_overflow     = sensor_overflow_flag;
    next_data_ready   = data_ready;
    next_data_overrun = data_overrun;
    next_result       = result;
    next_read_active  = data_read_active;
    if (measuring & meas_overflow)
      next_overflow = 1'b1;
    else if (meas_start)
      next_overflow = 1'b0;
    // Set wins over read-clear so a fresh sample is not missed
    if (meas_done & measuring)
      next_data_ready = 1'b1;
    else if (st_rd)
      next_data_ready = 1'b0;
    if (meas_overrun & streaming)
      next_data_overrun = 1'b1;
    else if (st_rd)
      next_data_overrun = 1'b0;
    // Results are frozen during a read interval so the host gets one coherent sample
    if (meas_done & measuring & ~data_read_active)
      next_result = {meas_z, meas_y, meas_x};
    if (st2_rd)
      next_read_active = 1'b0;
    else if (data_rd & streaming)
      next_read_active = 1'b1;
  end

  always @(posedge clk) begin
    if (reset | soft_rst | ctl1_wr) begin
      sensor_overflow_flag <= 1'b0;
      data_ready           <= 1'b0;
      data_overrun         <= 1'b0;
      data_read_active     <= 1'b0;
      result               <= 48'h0000_0000_0000;
    end else begin
      sensor_overflow_flag <= next_overflow;
      data_ready           <= next_data_ready;
      data_overrun         <= next_data_overrun;
      data_read_active     <= next_read_active;
      result               <= next_result;
    end
  end

  // Serial interface lock; soft reset does not release it since it cannot be written while locked
  always @* begin
    next_serial_enabled = serial_enabled;
    next_disable_key    = serial_disable_key;
    next_start_run      = start_run;
    if (!serial_enabled) begin
      if (other_byte)
        next_start_run = 4'h0;
      else if (start_condition) begin
        if (start_run == `MGCS_START_COUNT - 4'h1) begin
          next_serial_enabled = 1'b1;
          next_disable_key    = `MGCS_RESET_BYTE;
          next_start_run      = 4'h0;
        end else
          next_start_run = start_run + 4'h1;
      end
    end else if (soft_rst) begin
      next_disable_key = `MGCS_RESET_BYTE;
    end else if (wr & (reg_addr == `MGCS_ADDR_DISABLE_KEY)) begin
      next_disable_key = reg_wdata;
      next_start_run   = 4'h0;
      if (reg_wdata == `MGCS_DISABLE_CODE)
        next_serial_enabled = 1'b0;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      serial_enabled     <= 1'b1;
      serial_disable_key <= `MGCS_RESET_BYTE;
      start_run          <= 4'h0;
    end else begin
      serial_enabled     <= next_serial_enabled;
      serial_disable_key <= next_disable_key;
      start_run          <= next_start_run;
    end
  end

  // Read mux
  always @* begin
    next_rdata = 8'h00;
    case (reg_addr)
      `MGCS_ADDR_STATUS_ONE:  next_rdata = {6'h00, data_overrun, data_ready};
      8'h03:                  next_rdata = result[7:0];
      8'h04:                  next_rdata = result[15:8];
      8'h05:                  next_rdata = result[23:16];
      8'h06:                  next_rdata = result[31:24];
      8'h07:                  next_rdata = result[39:32];
      8'h08:                  next_rdata = result[47:40];
      `MGCS_ADDR_STATUS_TWO: begin
        next_rdata[`MGCS_BIT_WIDTH]    = output_16bit;
        next_rdata[`MGCS_BIT_OVERFLOW] = sensor_overflow_flag;
      end
      `MGCS_ADDR_CONTROL_ONE: next_rdata = {3'h0, output_16bit, op_mode};
      `MGCS_ADDR_CONTROL_TWO: next_rdata = 8'h00;
      `MGCS_ADDR_SELF_TEST:   next_rdata = self_test_control;
      `MGCS_ADDR_FACTORY_ONE: next_rdata = factory_test_one;
      `MGCS_ADDR_FACTORY_TWO: next_rdata = factory_test_two;
      `MGCS_ADDR_DISABLE_KEY: next_rdata = serial_disable_key;
      // Outside fuse mode the bytes are not valid; zero is returned
      `MGCS_ADDR_SENS_X:      next_rdata = mode_fuse ? SENS_X : 8'h00;
      `MGCS_ADDR_SENS_Y:      next_rdata = mode_fuse ? SENS_Y : 8'h00;
      `MGCS_ADDR_SENS_Z:      next_rdata = mode_fuse ? SENS_Z : 8'h00;
      default:                next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= rd;
      reg_rdata  <= rd ? next_rdata : 8'h00;
    end
  end

endmodule // mgcs_control_status

// File: bench/mgcs_cs_asserts.sv
// Concurrent checks on the magnetometer control ports
`timescale 1ns/1ps
module mgcs_cs_asserts (
  input wire       clk,
  input wire       reset,
  input wire       reg_write,
  input wire       reg_read,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_rvalid,
  input wire       start_condition,
  input wire [3:0] op_mode,
  input wire       output_16bit,
  input wire       self_field_on,
  input wire       serial_enabled,
  input wire       mode_fuse,
  input wire       mode_power_down
);
  wire wr_ok = reg_write && serial_enabled;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_lock_key: assert property (wr_ok && reg_addr == 8'h0f && reg_wdata == 8'h1b |=> !serial_enabled)
    else $error("key write left interface live");
  chk_lock_holds: assert property (!serial_enabled && !start_condition |=> !serial_enabled)
    else $error("lock dropped without start");
  chk_locked_silent: assert property (!serial_enabled |=> !reg_rvalid)
    else $error("read answered while locked");
  chk_mode_store: assert property (wr_ok && reg_addr == 8'h0a |=> op_mode == $past(reg_wdata[3:0]))
    else $error("mode code not stored");
  chk_width_bit: assert property (wr_ok && reg_addr == 8'h0a |=> output_16bit == $past(reg_wdata[4]))
    else $error("width bit not stored");
  chk_fuse_decode: assert property (wr_ok && reg_addr == 8'h0a && reg_wdata[3:0] == 4'hf
    |=> mode_fuse && !mode_power_down)
    else $error("fuse code decoded wrong");
  chk_self_field: assert property (wr_ok && reg_addr == 8'h0c && reg_wdata[6] |-> ##[1:2] self_field_on)
    else $error("self field not raised");
  chk_soft_reset: assert property (wr_ok && reg_addr == 8'h0b && reg_wdata[0] |=> op_mode == 4'h0)
    else $error("soft reset left control set");
endmodule // mgcs_cs_asserts

// File: bench/mgcs_front_model.sv
// Front-end stand-in: start, overflow and done pulses per request
`timescale 1ns/1ps
module mgcs_front_model (
  input  wire clk,
  input  wire go,
  input  wire ovf,
  output reg  meas_start = 1'b0,
  output reg  meas_done = 1'b0,
  output reg  meas_overflow = 1'b0
);
  reg [1:0] phase = 2'h0;
  always @(posedge clk) begin
    meas_start    <= go;
    meas_overflow <= (phase == 2'h1) && ovf;
    meas_done     <= (phase == 2'h2);
    phase         <= go ? 2'h1 : (phase == 2'h0 ? 2'h0 : phase + 2'h1);
  end
endmodule // mgcs_front_model

// File: bench/tb.sv
// Self-checking bench for the magnetometer control block
`timescale 1ns/1ps
module tb;
  localparam [27:0] CODES = 28'hf84_6210;
  reg         clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0, start_condition = 1'b0;
  reg         other_byte = 1'b0, go = 1'b0, ovf = 1'b0, w = 1'b0;
  reg  [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00;
  reg  [15:0] mx = 16'h0000;
  reg  [3:0]  code;
  wire [7:0]  reg_rdata;
  wire [3:0]  op_mode;
  wire        reg_rvalid, output_16bit, self_field_on, serial_enabled, data_read_active, meas_start, meas_done;
  wire        meas_overflow, m_pd, m_si, m_co, m_et, m_st, m_fu;
  integer     fails = 0, n_tests = 0, cyc = 0, i;
  mgcs_control_status #(.SENS_X(8'h3c), .SENS_Y(8'hc5), .SENS_Z(8'h81)) i_mgcs_control_status (
    .clk(clk), .reset(reset), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .start_condition(start_condition),
    .other_byte(other_byte), .meas_start(meas_start), .meas_done(meas_done), .meas_overflow(meas_overflow),
    .meas_overrun(1'b0), .meas_x(mx), .meas_y(~mx), .meas_z(mx), .op_mode(op_mode), .output_16bit(output_16bit),
    .self_field_on(self_field_on), .serial_enabled(serial_enabled), .data_read_active(data_read_active),
    .mode_power_down(m_pd), .mode_single(m_si), .mode_continuous(m_co), .mode_ext_trigger(m_et),
    .mode_self_test(m_st), .mode_fuse(m_fu));
  mgcs_front_model i_mgcs_front_model (.clk(clk), .go(go), .ovf(ovf), .meas_start(meas_start),
    .meas_done(meas_done), .meas_overflow(meas_overflow));
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input string what, input [8:0] seen, input [8:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // Strobes rise after an edge and fall one edge later, never twice in a step
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk); #1 reg_write = 1'b1; reg_addr = a; reg_wdata = d;
      @(posedge clk); #1 reg_write = 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [8:0] e, input string what);
    begin
      @(posedge clk); #1 reg_read = 1'b1; reg_addr = a;
      @(posedge clk); #1 reg_read = 1'b0;
      chk(what, {reg_rvalid, reg_rdata}, e);
    end
  endtask
  task meas(input o);
    begin
      @(posedge clk); #1 go = 1'b1; ovf = o;
      @(posedge clk); #1 go = 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  function [8:0] dec(input [3:0] c);
    dec = {3'h0, c == 4'h0, c == 4'h1, c == 4'h2 || c == 4'h6, c == 4'h4, c == 4'h8, c == 4'hf};
  endfunction
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin fails = fails + 1; wrap_up; end
  end
  initial begin
    i = $urandom(32'h0662);
    repeat (20) @(posedge clk);
    #1 reset = 1'b0;
    for (i = 9; i < 16; i = i + 1) if (i != 13 && i != 14) rd(i[7:0], 9'h100, "reset value");
    $display("reset values done");
    for (i = 0; i < 7; i = i + 1) begin
      code = CODES[i*4 +: 4];
      w = $urandom % 2;
      wr(8'h0a, {3'h0, w, code});
      chk("mode decode", {3'h0, m_pd, m_si, m_co, m_et, m_st, m_fu}, dec(code));
      rd(8'h0a, {4'h8, w, code}, "control one");
      rd(8'h09, {4'h8, w, 4'h0}, "width mirror");
    end
    $display("modes done");
    wr(8'h0a, 8'h11);
    meas(1'b1);
    rd(8'h09, 9'h118, "overflow set");
    meas(1'b0);
    rd(8'h09, 9'h110, "overflow cleared");
    meas(1'b1);
    wr(8'h0a, 8'h11);
    rd(8'h09, 9'h110, "status after write");
    $display("overflow done");
    wr(8'h0a, 8'h12);
    mx = $urandom;
    meas(1'b0);
    rd(8'h02, 9'h101, "status one");
    rd(8'h03, {1'b1, mx[7:0]}, "x low");
    chk("read interval", data_read_active, 9'h001);
    rd(8'h04, {1'b1, mx[15:8]}, "x high");
    rd(8'h09, 9'h110, "status end");
    chk("read interval", data_read_active, 9'h000);
    $display("data read done");
    wr(8'h0c, 8'h40);
    @(posedge clk); #1 chk("self field", self_field_on, 9'h001);
    wr(8'h0b, 8'h01);
    rd(8'h0a, 9'h100, "soft reset");
    rd(8'h0b, 9'h100, "reset bit");
    rd(8'h0c, 9'h100, "self test ctl");
    wr(8'h0a, 8'h0f);
    rd(8'h10, 9'h13c, "adjust x");
    rd(8'h11, 9'h1c5, "adjust y");
    rd(8'h12, 9'h181, "adjust z");
    wr(8'h0a, 8'h00);
    rd(8'h10, 9'h100, "adjust outside fuse");
    $display("control and fuse done");
    wr(8'h0f, 8'h1b);
    chk("interface live", serial_enabled, 9'h000);
    wr(8'h0f, 8'h00);
    rd(8'h0a, 9'h000, "locked read");
    for (i = 0; i < 16; i = i + 1) begin
      @(posedge clk); #1 start_condition = (i != 7); other_byte = (i == 7);
      if (i == 15) chk("run broken", serial_enabled, 9'h000);
    end
    @(posedge clk); #1 start_condition = 1'b0; other_byte = 1'b0;
    chk("eight starts", serial_enabled, 9'h001);
    wr(8'h0f, 8'h1b);
    reset = 1'b1;
    @(posedge clk); #1 reset = 1'b0;
    chk("reset unlock", serial_enabled, 9'h001);
    $display("lock done");
    wrap_up;
  end
endmodule // tb
bind mgcs_control_status mgcs_cs_asserts i_mgcs_cs_asserts (.clk(clk), .reset(reset), .reg_write(reg_write),
  .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rvalid(reg_rvalid),
  .start_condition(start_condition), .op_mode(op_mode), .output_16bit(output_16bit), .self_field_on(self_field_on),
  .serial_enabled(serial_enabled), .mode_fuse(mode_fuse), .mode_power_down(mode_power_down));
